// File: core/sdcad_map.vh
`ifndef SDCAD_MAP_VH
`define SDCAD_MAP_VH

// Command codes on {ras_n, cas_n, we_n} with chip select low
`define SDCAD_CMD_ACT 3'h3
`define SDCAD_CMD_PRE 3'h2
`define SDCAD_CMD_RD 3'h5
`define SDCAD_CMD_WR 3'h4
`define SDCAD_CMD_MRS 3'h0
`define SDCAD_CMD_REF 3'h1
`define SDCAD_CMD_BST 3'h6
`define SDCAD_CMD_NOP 3'h7

// Address field layout
`define SDCAD_ROW_W 12
`define SDCAD_COL_W 8
`define SDCAD_AP_BIT 10
`define SDCAD_MODE_W 14
`define SDCAD_LOC_W 20

// Byte mask to output buffer latency, in clocks
`define SDCAD_MASK_LAT 2

// Defaults for values set outside this block
`define SDCAD_DEF_CAS_LAT 2
`define SDCAD_DEF_BURST 1
`define SDCAD_FIFO_DEPTH 4

// Reset values
`define SDCAD_RST_MODE 14'h0000
`define SDCAD_RST_BANKS 4'h0

`endif

// File: core/sdcad_fifo.v
`timescale 1ns/1ns
`include "sdcad_map.vh"

// Small synchronous FIFO; flags are registered so ports come from flops
module sdcad_fifo #(
  parameter WIDTH = 16,
  parameter DEPTH = `SDCAD_FIFO_DEPTH,
  parameter AW = 2
) (
  input wire mclk,
  input wire reset,
  input wire [WIDTH-1:0] in_data,
  input wire in_valid,
  output reg in_ready,
  output wire [WIDTH-1:0] out_data,
  output reg out_valid,
  input wire out_ready
);

  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0] wr_ptr_r;
  reg [AW-1:0] rd_ptr_r;
  reg [AW:0] count_r;
  wire push;
  wire pop;
  wire [AW:0] count_nxt;

  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  assign count_nxt = count_r + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
  assign out_data = mem[rd_ptr_r];

  // Storage has no reset; only pointers and flags need a defined value
  always @(posedge mclk) begin
    if (push) begin
      mem[wr_ptr_r] <= in_data;
    end
  end

  // Pointers wrap naturally; DEPTH must be a power of two
  always @(posedge mclk or posedge reset) begin
    if (reset) begin
      wr_ptr_r <= {AW{1'b0}};
      rd_ptr_r <= {AW{1'b0}};
      count_r <= {(AW+1){1'b0}};
      in_ready <= 1'b1;
      out_valid <= 1'b0;
    end else begin
      if (push) begin
        wr_ptr_r <= wr_ptr_r + {{(AW-1){1'b0}}, 1'b1};
      end
      if (pop) begin
        rd_ptr_r <= rd_ptr_r + {{(AW-1){1'b0}}, 1'b1};
      end
      count_r <= count_nxt;
      in_ready <= (count_nxt != DEPTH[AW:0]);
      out_valid <= (count_nxt != {(AW+1){1'b0}});
    end
  end

endmodule // sdcad_fifo

// File: core/sdcad_decode.v
// What this block does
// - An activate captures all twelve address bits as the row of the bank.
// - Read and write take column bits 0-7; bit 10 asks for auto precharge.
// - The bank row and the column together name one of about 1M locations.
// - A precharge with address bit 10 high precharges every bank.
// - A mode register set takes its operation code from the bank select and address inputs.
// - Commands decode only while chip select is low; high masks them all.
// - RAS, CAS and WE are sampled each rising edge and decoded together.
// - Chip select and RAS low, CAS and WE high, activate the bank.
// - Chip select, RAS and WE low with CAS high precharge the bank to idle.
// - RAS high with chip select and CAS low starts a column access.
// - Byte masks gate output buffers on reads and mask write data on writes.
// - The 16-bit data bus moves on rising edges both ways and is maskable.
// - A column access with WE high is a read, with WE low a write.
// - On reads the byte masks act on the outputs two clocks after sampling.
`timescale 1ns/1ns
`include "sdcad_map.vh"

module sdcad_decode #(
  parameter CAS_LAT = `SDCAD_DEF_CAS_LAT,
  parameter BURST_LEN = `SDCAD_DEF_BURST,
  parameter FIFO_DEPTH = `SDCAD_FIFO_DEPTH
) (
  input wire mclk,
  input wire reset,
  input wire chip_select_n,
  input wire ras_n,
  input wire cas_n,
  input wire we_n,
  input wire bank_select_low_bit,
  input wire bank_select_high_bit,
  input wire [11:0] addr,
  input wire lower_byte_mask,
  input wire upper_byte_mask,
  input wire [15:0] dq_in,
  output reg [15:0] dq_out,
  output reg [15:0] dq_oe_n,
  output reg act_pulse,
  output reg pre_pulse,
  output reg pre_all_pulse,
  output reg rd_pulse,
  output reg wr_pulse,
  output reg mrs_pulse,
  output reg cmd_error,
  output reg [1:0] cmd_bank,
  output reg [3:0] bank_active,
  output reg [13:0] mode_code,
  output reg access_valid,
  output reg access_write,
  output reg [1:0] access_bank,
  output reg [19:0] access_loc,
  output reg [15:0] wr_data,
  output reg [1:0] wr_byte_en,
  input wire [15:0] rd_data,
  input wire rd_data_valid,
  output wire rd_data_ready
);

  // Pin decode, combinational from the sampled pins
  wire cs_on;
  wire [2:0] cmd_code;
  wire [1:0] bank_sel;
  wire is_act;
  wire is_pre;
  wire is_rd;
  wire is_wr;
  wire is_mrs;
  wire is_bst;
  wire ap_bit;

  assign cs_on = ~chip_select_n;
  assign cmd_code = {ras_n, cas_n, we_n};
  assign bank_sel = {bank_select_high_bit, bank_select_low_bit};
  // Bit 10 doubles as auto precharge and precharge-all select
  assign ap_bit = addr[`SDCAD_AP_BIT];
  assign is_act = cs_on && (cmd_code == `SDCAD_CMD_ACT);
  assign is_pre = cs_on && (cmd_code == `SDCAD_CMD_PRE);
  assign is_rd = cs_on && (cmd_code == `SDCAD_CMD_RD);
  assign is_wr = cs_on && (cmd_code == `SDCAD_CMD_WR);
  assign is_mrs = cs_on && (cmd_code == `SDCAD_CMD_MRS);
  // Refresh and no-op match nothing here and are ignored
  assign is_bst = cs_on && (cmd_code == `SDCAD_CMD_BST);

  // Open row per bank
  reg [`SDCAD_ROW_W-1:0] row_r [0:3];
  wire [3:0] act_hit;
  wire [3:0] pre_hit;

  // Burst engine state
  localparam BS_IDLE = 2'h0;
  localparam BS_READ = 2'h1;
  localparam BS_WRITE = 2'h2;

  reg [1:0] bstate_r;
  reg [1:0] bstate_nxt;
  reg [7:0] beat_cnt_r;
  reg [7:0] beat_cnt_nxt;
  reg [`SDCAD_COL_W-1:0] col_r;
  reg [`SDCAD_COL_W-1:0] col_nxt;
  reg [1:0] bbank_r;
  reg [1:0] bbank_nxt;
  reg ap_r;
  reg ap_nxt;
  reg beat_now;
  reg beat_write;
  reg [`SDCAD_COL_W-1:0] beat_col;
  reg [1:0] beat_bank;
  reg ap_close;
  reg [1:0] ap_bank;

  // Read data return path
  wire [15:0] fifo_data;
  wire fifo_valid;
  reg [CAS_LAT-1:0] slot_r;
  wire [CAS_LAT:0] slot_shift;
  reg [`SDCAD_MASK_LAT-1:0] lmask_d_r;
  reg [`SDCAD_MASK_LAT-1:0] umask_d_r;
  wire out_slot;
  wire out_pop;
  wire lmask_late;
  wire umask_late;

  // Bank state flips, one generate lane per bank
  genvar g;
  generate
    for (g = 0; g < 4; g = g + 1) begin : g_bank
      assign act_hit[g] = is_act && (bank_sel == g);
      // Precharge all ignores the bank bits
      assign pre_hit[g] = is_pre && (ap_bit || bank_sel == g);

      always @(posedge mclk or posedge reset) begin
        if (reset) begin
          row_r[g] <= {`SDCAD_ROW_W{1'b0}};
        end else if (act_hit[g]) begin
          row_r[g] <= addr;
        end
      end

      // Activate sets, any precharge or auto precharge clears
      always @(posedge mclk or posedge reset) begin
        if (reset) begin
          bank_active[g] <= 1'b0;
        end else if (act_hit[g]) begin
          bank_active[g] <= 1'b1;
        end else if (pre_hit[g] || (ap_close && ap_bank == g)) begin
          bank_active[g] <= 1'b0;
        end
      end
    end
  endgenerate

  // Burst sequencing; a new column command restarts the burst
  always @* begin
    bstate_nxt = bstate_r;
    beat_cnt_nxt = beat_cnt_r;
    col_nxt = col_r;
    bbank_nxt = bbank_r;
    ap_nxt = ap_r;
    beat_now = 1'b0;
    beat_write = 1'b0;
    beat_col = col_r;
    beat_bank = bbank_r;
    ap_close = 1'b0;
    ap_bank = bbank_r;
    if (is_rd || is_wr) begin
      // First beat is issued on the command edge itself
      beat_now = 1'b1;
      beat_write = is_wr;
      beat_col = addr[`SDCAD_COL_W-1:0];
      beat_bank = bank_sel;
      // An open burst with auto precharge closes its bank when cut short
      ap_close = (bstate_r != BS_IDLE) && ap_r;
      col_nxt = addr[`SDCAD_COL_W-1:0] + 8'h01;
      bbank_nxt = bank_sel;
      ap_nxt = ap_bit;
      beat_cnt_nxt = BURST_LEN[7:0] - 8'h01;
      if (BURST_LEN == 1) begin
        bstate_nxt = BS_IDLE;
        if (ap_bit) begin
          ap_close = 1'b1;
          ap_bank = bank_sel;
        end
      end else if (is_wr) begin
        bstate_nxt = BS_WRITE;
      end else begin
        bstate_nxt = BS_READ;
      end
    end else begin
      case (bstate_r)
        BS_IDLE: begin
          bstate_nxt = BS_IDLE;
        end
        BS_READ, BS_WRITE: begin
          if (is_bst || (is_pre && pre_hit[bbank_r])) begin
            // Burst stop or precharge of this bank ends the burst
            bstate_nxt = BS_IDLE;
          end else begin
            beat_now = 1'b1;
            beat_write = (bstate_r == BS_WRITE);
            col_nxt = col_r + 8'h01; // Linear wrap inside the page
            beat_cnt_nxt = beat_cnt_r - 8'h01;
            if (beat_cnt_r == 8'h01) begin
              bstate_nxt = BS_IDLE;
              ap_close = ap_r;
            end
          end
        end
        default: begin
          bstate_nxt = BS_IDLE;
        end
      endcase
    end
  end

  always @(posedge mclk or posedge reset) begin
    if (reset) begin
      bstate_r <= BS_IDLE;
      beat_cnt_r <= 8'h00;
      col_r <= {`SDCAD_COL_W{1'b0}};
      bbank_r <= 2'h0;
      ap_r <= 1'b0;
    end else begin
      bstate_r <= bstate_nxt;
      beat_cnt_r <= beat_cnt_nxt;
      col_r <= col_nxt;
      bbank_r <= bbank_nxt;
      ap_r <= ap_nxt;
    end
  end

  // Registered command reports and mode register
  always @(posedge mclk or posedge reset) begin
    if (reset) begin
      act_pulse <= 1'b0;
      pre_pulse <= 1'b0;
      pre_all_pulse <= 1'b0;
      rd_pulse <= 1'b0;
      wr_pulse <= 1'b0;
      mrs_pulse <= 1'b0;
      cmd_error <= 1'b0;
      cmd_bank <= 2'h0;
      mode_code <= `SDCAD_RST_MODE;
    end else begin
      act_pulse <= is_act;
      pre_pulse <= is_pre && !ap_bit;
      pre_all_pulse <= is_pre && ap_bit;
      rd_pulse <= is_rd;
      wr_pulse <= is_wr;
      mrs_pulse <= is_mrs;
      // Flags misuse: reopening an open bank, accessing an idle one, or a mode set while any bank is open
      // The command still runs; the flag only reports it
      cmd_error <= (is_act && bank_active[bank_sel]) ||
                   ((is_rd || is_wr) && !bank_active[bank_sel]) ||
                   (is_mrs && (bank_active != `SDCAD_RST_BANKS));
      if (is_act || is_pre || is_rd || is_wr) begin
        cmd_bank <= bank_sel;
      end
      if (is_mrs) begin
        mode_code <= {bank_sel, addr};
      end
    end
  end

  // Array access per beat; write data sampled on the beat edge
  always @(posedge mclk or posedge reset) begin
    if (reset) begin
      access_valid <= 1'b0;
      access_write <= 1'b0;
      access_bank <= 2'h0;
      access_loc <= {`SDCAD_LOC_W{1'b0}};
      wr_data <= 16'h0000;
      wr_byte_en <= 2'h0;
    end else begin
      access_valid <= beat_now;
      if (beat_now) begin
        access_write <= beat_write;
        access_bank <= beat_bank;
        access_loc <= {row_r[beat_bank], beat_col};
        wr_data <= beat_write ? dq_in : 16'h0000;
        // A high mask drops that byte from the write
        wr_byte_en <= beat_write ?
                      {~upper_byte_mask, ~lower_byte_mask} : 2'h0;
      end
    end
  end

  // Output slots run CAS_LAT clocks behind each read beat
  always @(posedge mclk or posedge reset) begin
    if (reset) begin
      slot_r <= {CAS_LAT{1'b0}};
      lmask_d_r <= {`SDCAD_MASK_LAT{1'b0}};
      umask_d_r <= {`SDCAD_MASK_LAT{1'b0}};
    end else begin
      slot_r <= slot_shift[CAS_LAT-1:0];
      // Masks are delayed so they gate the bus two clocks later
      lmask_d_r <= {lmask_d_r[0], lower_byte_mask};
      umask_d_r <= {umask_d_r[0], upper_byte_mask};
    end
  end

  // Stage zero is the read beat itself; the top tap is the output slot
  assign slot_shift = {slot_r, beat_now && !beat_write};
  assign out_slot = slot_shift[CAS_LAT];
  // Mask taps do not follow CAS_LAT: the mask latency is fixed
  assign lmask_late = lmask_d_r[`SDCAD_MASK_LAT-1];
  assign umask_late = umask_d_r[`SDCAD_MASK_LAT-1];
  // Data is consumed even if masked, keeping the burst in step
  assign out_pop = out_slot && fifo_valid;

  // Read words from the array queue here; an idle bus stalls the array
  sdcad_fifo #(
    .WIDTH(16),
    .DEPTH(FIFO_DEPTH),
    .AW(2)
  ) u_rd_fifo (
    .mclk(mclk),
    .reset(reset),
    .in_data(rd_data),
    .in_valid(rd_data_valid),
    .in_ready(rd_data_ready),
    .out_data(fifo_data),
    .out_valid(fifo_valid),
    .out_ready(out_slot)
  );

  // Drive both byte lanes together, each with its own enable; enables are active low
  always @(posedge mclk or posedge reset) begin
    if (reset) begin
      dq_out <= 16'h0000;
      dq_oe_n <= 16'hffff;
    end else begin
      if (out_pop) begin
        dq_out <= fifo_data;
      end
      dq_oe_n[7:0] <= {8{!(out_pop && !lmask_late)}};
      dq_oe_n[15:8] <= {8{!(out_pop && !umask_late)}};
    end
  end

endmodule // sdcad_decode

// File: bench/sdcad_monitor.sv
`timescale 1ns/1ns
`include "sdcad_map.vh"

module sdcad_monitor (
  input wire mclk,
  input wire reset,
  input wire chip_select_n,
  input wire ras_n,
  input wire cas_n,
  input wire we_n,
  input wire bank_select_low_bit,
  input wire bank_select_high_bit,
  input wire [11:0] addr,
  input wire lower_byte_mask,
  input wire upper_byte_mask,
  input wire [15:0] dq_in,
  input wire [15:0] dq_oe_n,
  input wire act_pulse,
  input wire pre_pulse,
  input wire pre_all_pulse,
  input wire rd_pulse,
  input wire wr_pulse,
  input wire mrs_pulse,
  input wire [1:0] cmd_bank,
  input wire [3:0] bank_active,
  input wire [13:0] mode_code,
  input wire access_valid,
  input wire access_write,
  input wire [19:0] access_loc,
  input wire [15:0] wr_data,
  input wire [1:0] wr_byte_en
);
  // Decoded view of the pins, valid only while selected
  wire sel = !chip_select_n;
  wire [2:0] code = {ras_n, cas_n, we_n};
  wire [1:0] bk = {bank_select_high_bit, bank_select_low_bit};
  wire [1:0] msk = {upper_byte_mask, lower_byte_mask};
  wire [7:0] col = addr[7:0];
  wire [13:0] op = {bk, addr};
  wire is_act = sel && code == `SDCAD_CMD_ACT;
  wire is_pre = sel && code == `SDCAD_CMD_PRE;
  wire is_rd = sel && code == `SDCAD_CMD_RD;
  wire is_wr = sel && code == `SDCAD_CMD_WR;
  wire is_mrs = sel && code == `SDCAD_CMD_MRS;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);

  chk_act_bank: assert property (is_act |=> act_pulse &&
    cmd_bank == $past(bk) && bank_active[cmd_bank]) else $error("activate");
  chk_deselect_masks: assert property (!sel |=> !(act_pulse |
    pre_pulse | pre_all_pulse | rd_pulse | wr_pulse | mrs_pulse))
    else $error("deselect");
  chk_pre_all: assert property (is_pre && addr[10] |=>
    pre_all_pulse && !pre_pulse && bank_active == 4'h0) else $error("pre all");
  chk_pre_bank: assert property (is_pre && !addr[10] |=> pre_pulse &&
    cmd_bank == $past(bk) && !bank_active[cmd_bank]) else $error("pre bank");
  chk_read_col: assert property (is_rd |=> rd_pulse &&
    access_valid && !access_write && access_loc[7:0] == $past(col))
    else $error("read column");
  chk_write_data: assert property (is_wr |=> wr_pulse &&
    access_write && wr_data == $past(dq_in) && wr_byte_en == ~$past(msk))
    else $error("write data");
  chk_mode_code: assert property (is_mrs |=>
    mrs_pulse && mode_code == $past(op)) else $error("mode code");
  chk_row_capture: assert property (is_act ##1
    ((is_rd || is_wr) && bk == $past(bk)) |=>
    access_loc[19:8] == $past(addr, 2)) else $error("row capture");
  chk_lower_lat: assert property (lower_byte_mask ##2 1 |=>
    &dq_oe_n[7:0]) else $error("lower mask latency");
  chk_upper_lat: assert property (upper_byte_mask ##2 1 |=>
    &dq_oe_n[15:8]) else $error("upper mask latency");

  cover property (is_act ##1 is_wr);
  cover property (is_pre && addr[10]);
  cover property (!dq_oe_n[0]);
endmodule // sdcad_monitor

bind sdcad_decode sdcad_monitor u_sdcad_monitor (
  .mclk(mclk),
  .reset(reset),
  .chip_select_n(chip_select_n),
  .ras_n(ras_n),
  .cas_n(cas_n),
  .we_n(we_n),
  .bank_select_low_bit(bank_select_low_bit),
  .bank_select_high_bit(bank_select_high_bit),
  .addr(addr),
  .lower_byte_mask(lower_byte_mask),
  .upper_byte_mask(upper_byte_mask),
  .dq_in(dq_in),
  .dq_oe_n(dq_oe_n),
  .act_pulse(act_pulse),
  .pre_pulse(pre_pulse),
  .pre_all_pulse(pre_all_pulse),
  .rd_pulse(rd_pulse),
  .wr_pulse(wr_pulse),
  .mrs_pulse(mrs_pulse),
  .cmd_bank(cmd_bank),
  .bank_active(bank_active),
  .mode_code(mode_code),
  .access_valid(access_valid),
  .access_write(access_write),
  .access_loc(access_loc),
  .wr_data(wr_data),
  .wr_byte_en(wr_byte_en)
);

// File: bench/sdcad_ctrl_model.sv
`timescale 1ns/1ns

// Controller side: drives pins from bench requests, deselects when idle
module sdcad_ctrl_model (
  input wire mclk,
  input wire go,
  input wire [2:0] code,
  input wire [1:0] bnk,
  input wire [11:0] a,
  input wire [1:0] msk,
  input wire [15:0] d,
  input wire [15:0] dq_out,
  input wire [15:0] dq_oe_n,
  output wire chip_select_n,
  output wire [2:0] pins,
  output wire [1:0] bank,
  output wire [11:0] addr,
  output wire [1:0] mask,
  output wire [15:0] dq_in
);
  reg [11:0] last_a_r = 12'h000;
  reg [15:0] last_d_r = 16'h0000;
  wire [15:0] drv;
  // Idle bus shows inverted old value so stale data never looks valid
  always @(posedge mclk) begin
    if (go) begin
      last_a_r <= a;
      last_d_r <= d;
    end
  end
  assign chip_select_n = !go;
  assign pins = code;
  assign bank = bnk;
  assign addr = go ? a : ~last_a_r;
  assign mask = msk;
  assign drv = go ? d : ~last_d_r;
  // Shared data wire: device wins on lanes it enables
  assign dq_in = (dq_out & ~dq_oe_n) | (drv & dq_oe_n);
endmodule // sdcad_ctrl_model

// File: bench/tb_top.sv
`timescale 1ns/1ns
`include "sdcad_map.vh"

module tb_top;
  reg mclk = 1'b0;
  reg reset = 1'b1;
  reg go = 1'b0;
  reg [2:0] code = 3'h7;
  reg [1:0] bnk = 2'h0;
  reg [11:0] a = 12'h000;
  reg [1:0] msk = 2'h0;
  reg [15:0] d = 16'h0000;
  reg [15:0] rd_data = 16'h0000;
  reg rd_data_valid = 1'b0;
  integer n_mismatch = 0;
  integer tests_run = 0;
  integer i;
  wire cs_n, act, pre, pre_all, rd, wr, mrs, av, aw, rdy, err;
  wire [2:0] pins;
  wire [1:0] bank, mask, cbank, abank, ben;
  wire [11:0] addr;
  wire [15:0] dq_in, dq_out, oe_n, wdata;
  wire [3:0] bact;
  wire [13:0] mode;
  wire [19:0] loc;

  sdcad_ctrl_model u_sdcad_ctrl_model (.mclk(mclk), .go(go), .code(code),
    .bnk(bnk), .a(a), .msk(msk), .d(d), .dq_out(dq_out), .dq_oe_n(oe_n),
    .chip_select_n(cs_n), .pins(pins), .bank(bank), .addr(addr),
    .mask(mask), .dq_in(dq_in));

  sdcad_decode u_sdcad_decode (.mclk(mclk), .reset(reset),
    .chip_select_n(cs_n), .ras_n(pins[2]), .cas_n(pins[1]), .we_n(pins[0]),
    .bank_select_low_bit(bank[0]), .bank_select_high_bit(bank[1]),
    .addr(addr), .lower_byte_mask(mask[0]), .upper_byte_mask(mask[1]),
    .dq_in(dq_in), .dq_out(dq_out), .dq_oe_n(oe_n), .act_pulse(act),
    .pre_pulse(pre), .pre_all_pulse(pre_all), .rd_pulse(rd), .wr_pulse(wr),
    .mrs_pulse(mrs), .cmd_error(err), .cmd_bank(cbank), .bank_active(bact),
    .mode_code(mode), .access_valid(av), .access_write(aw),
    .access_bank(abank), .access_loc(loc), .wr_data(wdata),
    .wr_byte_en(ben), .rd_data(rd_data), .rd_data_valid(rd_data_valid),
    .rd_data_ready(rdy));

  // 20 MHz clock
  initial begin
    forever #25 mclk = ~mclk;
  end

  task chk(input string n, input logic [19:0] e, input logic [19:0] s);
    tests_run = tests_run + 1;
    if (s !== e) begin
      n_mismatch = n_mismatch + 1;
      $display("MISMATCH %s expected %h seen %h", n, e, s);
    end
  endtask

  // Called at a falling edge; returns one falling edge after the command
  task cmd(input [2:0] c, input [1:0] b, input [11:0] ad, input [1:0] m,
           input [15:0] dd, input g);
    go = g;
    code = c;
    bnk = b;
    a = ad;
    msk = m;
    d = dd;
    @(negedge mclk);
  endtask

  task idle;
    go = 1'b0;
    msk = 2'h0;
    @(negedge mclk);
  endtask

  task t_act;
    for (i = 0; i < 4; i = i + 1) begin
      cmd(`SDCAD_CMD_ACT, i, 12'h123 + i, 2'h0, 16'h0, 1'b1);
      chk("act_pulse", 1, act);
      chk("cmd_bank", i, cbank);
      chk("bank_on", 1, bact[i]);
    end
    idle;
    chk("act_drop", 0, act);
    cmd(`SDCAD_CMD_PRE, 2'h0, 12'h400, 2'h0, 16'h0, 1'b0);
    chk("desel_pre", 0, pre_all);
    chk("desel_banks", 4'hf, bact);
    $display("test act done");
  endtask

  task t_pre;
    cmd(`SDCAD_CMD_PRE, 2'h1, 12'h000, 2'h0, 16'h0, 1'b1);
    chk("pre_pulse", 1, pre);
    chk("pre_banks", 4'hd, bact);
    cmd(`SDCAD_CMD_PRE, 2'h2, 12'h400, 2'h0, 16'h0, 1'b1);
    chk("pre_all", 1, pre_all);
    chk("all_banks", 4'h0, bact);
    idle;
    $display("test pre done");
  endtask

  task t_wr;
    cmd(`SDCAD_CMD_ACT, 2'h3, 12'habc, 2'h0, 16'h0, 1'b1);
    cmd(`SDCAD_CMD_WR, 2'h3, 12'h405, 2'h1, 16'h1234, 1'b1);
    chk("wr_valid", 1, av);
    chk("wr_kind", 1, aw);
    chk("wr_bank", 3, abank);
    chk("wr_loc", 20'habc05, loc);
    chk("wr_data", 16'h1234, wdata);
    chk("wr_en", 2'h2, ben);
    chk("autopre", 4'h0, bact);
    idle;
    $display("test write done");
  endtask

  task t_mrs;
    cmd(`SDCAD_CMD_MRS, 2'h2, 12'h023, 2'h0, 16'h0, 1'b1);
    chk("mrs_pulse", 1, mrs);
    chk("mode_code", 14'h2023, mode);
    idle;
    $display("test mode done");
  endtask

  task t_rd;
    rd_data_valid = 1'b1;
    for (i = 0; i < 4; i = i + 1) begin
      rd_data = 16'ha000 + i;
      @(negedge mclk);
    end
    rd_data_valid = 1'b0;
    @(negedge mclk);
    chk("fifo_full", 0, rdy);
    cmd(`SDCAD_CMD_ACT, 2'h0, 12'h111, 2'h0, 16'h0, 1'b1);
    for (i = 0; i < 5; i = i + 1) begin
      cmd(`SDCAD_CMD_RD, 2'h0, 12'h010 + i, (i == 0) ? 2'h2 : 2'h0, 16'h0, 1);
      chk("rd_kind", 0, aw);
      idle;
      idle;
      if (i == 0) chk("rd_oe_mask", 16'hff00, oe_n);
      else if (i < 4) chk("rd_oe", 16'h0000, oe_n);
      else chk("rd_empty", 16'hffff, oe_n);
      if (i > 0 && i < 4) chk("rd_word", 16'ha000 + i, dq_out);
      idle;
      chk("rd_release", 16'hffff, oe_n);
    end
    chk("fifo_room", 1, rdy);
    $display("test read done");
  endtask

  // Misuse flag, then a mid-run reset with a bank open and a mode set
  task t_rst;
    cmd(`SDCAD_CMD_RD, 2'h1, 12'h000, 2'h0, 16'h0, 1'b1);
    chk("err_idle", 1, err);
    cmd(`SDCAD_CMD_ACT, 2'h1, 12'h055, 2'h0, 16'h0, 1'b1);
    chk("err_clear", 0, err);
    cmd(`SDCAD_CMD_ACT, 2'h1, 12'h055, 2'h0, 16'h0, 1'b1);
    chk("err_reopen", 1, err);
    idle;
    reset = 1'b1;
    @(negedge mclk);
    chk("rst_banks", 4'h0, bact);
    chk("rst_mode", 14'h0000, mode);
    chk("rst_oe", 16'hffff, oe_n);
    chk("rst_ready", 1, rdy);
    reset = 1'b0;
    idle;
    $display("test reset done");
  endtask

  task conclude;
    $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // Watchdog against a hung sequence
  initial begin
    repeat (5000) @(posedge mclk);
    n_mismatch = n_mismatch + 1;
    conclude;
  end

  initial begin
    repeat (8) @(posedge mclk);
    @(negedge mclk);
    reset = 1'b0;
    @(negedge mclk);
    t_act;
    t_pre;
    t_wr;
    t_mrs;
    t_rst;
    t_rd;
    conclude;
  end
endmodule // tb_top
